// ===== rtl/ddr2_pin_regs.vh
// constants for the pin-level command decode of a x16 ddr2 device
// assumes inclusion by rtl/ddr2_pin_command_decode.v and rtl/ddr2_lane_path.v
`ifndef DDR2_PIN_REGS_VH
`define DDR2_PIN_REGS_VH
`define ROW_W          14
`define COL_W          10
`define AUTOPRE_BIT    10
`define BANK_W         3
`define BANKS          8
`define DATA_W         16
`define BYTE_W         8
`define CMD_W          3
// command codes {row_strobe_n, column_strobe_n, write_select_n}
`define CMD_ROW_OPEN   3'h3
`define CMD_PRECHARGE  3'h2
`define CMD_READ       3'h5
`define CMD_WRITE      3'h4
// extended config 1 bit positions (bit ten drives strobe complements)
`define ECR1_STROBE_COMP_OFF 10
`define ECR1_TERM_LO   2
`define ECR1_TERM_HI   6
`define ECR1_W         14
`define ECR1_RESET     14'h0000
// precharge finish time in cycles of clk
`define PRE_CYCLES     4'h3
`endif

// ===== rtl/ddr2_lane_path.v
// one byte lane: double rate capture and drive, mask and strobe control
// assumes the caller gives synchronised link-clock edges in the clk domain
`include "ddr2_pin_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module ddr2_lane_path (
  input  wire                 clk,           // system clock
  input  wire                 rst_sync_b,    // synchronised reset, active low
  input  wire                 rise_edge,     // link clock rising crossing
  input  wire                 fall_edge,     // link clock falling crossing
  input  wire                 wr_window,     // write data expected
  input  wire                 rd_window,     // read data to drive
  input  wire                 comp_en,       // complementary strobe enabled
  input  wire [`BYTE_W-1:0]   dq_in_s,       // synchronised lane data in
  input  wire                 mask_s,        // synchronised lane mask
  input  wire [`BYTE_W-1:0]   rd_byte,       // byte to drive on read
  output reg  [`BYTE_W-1:0]   wr_byte_q,     // captured write byte
  output reg                  wr_valid_q,    // write byte stored this cycle
  output reg  [`BYTE_W-1:0]   dq_out_q,      // lane data out
  output wire                 dq_oe,         // lane data drive enable
  output reg                  strobe_out_q,  // strobe out
  output wire                 strobe_oe,     // strobe drive enable
  output wire                 strobe_c_out,  // complement strobe out
  output wire                 strobe_c_oe    // complement drive enable
);
  // capture on both crossings, masked bytes are not stored
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wr_byte_q  <= 8'h00;
      wr_valid_q <= 1'b0;
    end else begin
      wr_valid_q <= 1'b0;
      if (wr_window && (rise_edge || fall_edge) && !mask_s) begin
        wr_byte_q  <= dq_in_s;
        wr_valid_q <= 1'b1;
      end
    end
  end
  // read drive: data and strobe toggle on each crossing
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      dq_out_q     <= 8'h00;
      strobe_out_q <= 1'b0;
    end else if (rd_window && (rise_edge || fall_edge)) begin
      dq_out_q     <= rd_byte;
      strobe_out_q <= rise_edge;
    end else if (!rd_window) begin
      strobe_out_q <= 1'b0;
    end
  end
  assign dq_oe        = rd_window;
  assign strobe_oe    = rd_window;
  // complement is always the inverse of the true strobe; only its drive enable needs comp_en
  assign strobe_c_out = ~strobe_out_q;
  assign strobe_c_oe  = rd_window & comp_en;
endmodule
`default_nettype wire

// ===== rtl/ddr2_pin_command_decode.v
// pin-level command decode and byte-lane control of a x16 ddr2 device
// assumes clock_true/clock_comp and all pins are asynchronous to clk
// Notes on behaviour
// - row-open captures all fourteen address lines as the row.
// - read/write take column from address 0-9; bit ten requests auto precharge.
// - chip select sampled high masks every command.
// - cs, row strobe low, column and write high: row open, bank active.
// - cs, row strobe low, column high, write low: precharge, bank idles after.
// - cs low, row high, column low: read if write high, else write.
// - command inputs latched at clock_true rising, clock_comp falling.
// - lower strobe times data 0-7, upper strobe times data 8-15.
// - strobes work single-ended or differential, driven on reads only.
// - config bit ten set disables all complementary strobes together.
// - byte lane with mask high is not stored during write.
// - data moves on both clock crossings.
// - termination_enable terminates data, strobes, complements and masks.
// - termination_enable ignored when config disables termination.
// - bank select picks one of eight banks for the command.
`include "ddr2_pin_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module ddr2_pin_command_decode (
  input  wire                 clk,                    // system clock 125 MHz
  input  wire                 rst_b,                  // async reset, active low
  input  wire                 clock_true,             // link clock true
  input  wire                 clock_comp,             // link clock complement
  input  wire                 chip_select_n,          // chip select, active low
  input  wire                 row_strobe_n,           // row strobe, active low
  input  wire                 column_strobe_n,        // column strobe, active low
  input  wire                 write_select_n,         // write select, active low
  input  wire [`ROW_W-1:0]    address_lines,          // address pins
  input  wire [`BANK_W-1:0]   bank_select,            // bank select pins
  input  wire                 termination_enable,     // termination request pin
  input  wire [`ECR1_W-1:0]   extended_config_reg1,   // extended config 1 value
  input  wire                 wr_window,              // write burst active
  input  wire                 rd_window,              // read burst active
  input  wire [`DATA_W-1:0]   data_lines_in,          // data pins in
  output wire [`DATA_W-1:0]   data_lines_out,         // data pins out
  output wire [`DATA_W-1:0]   data_lines_oe,          // data pins enable
  input  wire                 lower_byte_mask,        // mask for data 0-7
  input  wire                 upper_byte_mask,        // mask for data 8-15
  input  wire [`DATA_W-1:0]   rd_data,                // word to return on read
  output wire [`DATA_W-1:0]   wr_data,                // stored write word
  output wire [1:0]           wr_lane_valid,          // per-lane store pulse
  output wire                 lower_byte_strobe_out,  // lower strobe out
  output wire                 lower_byte_strobe_oe,   // lower strobe enable
  output wire                 lower_byte_strobe_comp_out, // lower comp out
  output wire                 lower_byte_strobe_comp_oe,  // lower comp enable
  output wire                 upper_byte_strobe_out,  // upper strobe out
  output wire                 upper_byte_strobe_oe,   // upper strobe enable
  output wire                 upper_byte_strobe_comp_out, // upper comp out
  output wire                 upper_byte_strobe_comp_oe,  // upper comp enable
  output reg                  row_open_cmd_q,         // row-open pulse
  output reg                  precharge_q,            // precharge pulse
  output reg                  read_q,                 // read pulse
  output reg                  write_q,                // write pulse
  output reg  [`BANK_W-1:0]   cmd_bank_q,             // bank of last command
  output reg  [`ROW_W-1:0]    row_addr_q,             // captured row
  output reg  [`COL_W-1:0]    col_addr_q,             // captured column
  output reg                  auto_pre_q,             // auto precharge flag
  output reg  [`BANKS-1:0]    bank_active_q,          // open banks
  output reg                  term_on_q               // termination applied
);
  // reset release through two flops
  reg rst_s1_q;
  reg rst_sync_b;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q   <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_s1_q   <= 1'b1;
      rst_sync_b <= rst_s1_q;
    end
  end

  // all pins pass two flops; first stage read only by second
  localparam SW = 4 + `ROW_W + `BANK_W + 1 + `DATA_W + 2 + 2;
  wire [SW-1:0] pin_raw = {clock_true, clock_comp, chip_select_n, row_strobe_n,
                           column_strobe_n, write_select_n, address_lines,
                           bank_select, termination_enable, data_lines_in,
                           lower_byte_mask, upper_byte_mask};
  reg  [SW-1:0] pin_s1_q;
  reg  [SW-1:0] pin_s2_q;
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pin_s1_q <= {SW{1'b0}};
      pin_s2_q <= {SW{1'b0}};
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end
  wire                ck_t  = pin_s2_q[SW-1];
  wire                ck_c  = pin_s2_q[SW-2];
  wire                cs_n  = pin_s2_q[SW-3];
  wire [`CMD_W-1:0]   cmd   = pin_s2_q[SW-4:SW-6];
  wire [`ROW_W-1:0]   addr  = pin_s2_q[SW-7:SW-6-`ROW_W];
  wire [`BANK_W-1:0]  bank  = pin_s2_q[SW-7-`ROW_W:SW-6-`ROW_W-`BANK_W];
  // low end of the vector: termination pin, data word, then the two masks
  wire                odt_s = pin_s2_q[`DATA_W+2];
  wire [`DATA_W-1:0]  dq_s  = pin_s2_q[`DATA_W+1:2];
  wire                ldm_s = pin_s2_q[1];
  wire                udm_s = pin_s2_q[0];

  // crossing detect; true and comp must disagree to count
  reg ck_t_d_q;
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ck_t_d_q <= 1'b0;
    end else begin
      ck_t_d_q <= ck_t;
    end
  end
  wire rise_edge = ck_t & ~ck_t_d_q & ~ck_c;
  wire fall_edge = ~ck_t & ck_t_d_q & ck_c;

  // command decode, only on the rising crossing with chip select low
  wire cmd_take = rise_edge & ~cs_n;
  wire is_open  = cmd_take & (cmd == `CMD_ROW_OPEN);
  wire is_pre   = cmd_take & (cmd == `CMD_PRECHARGE);
  wire is_rd    = cmd_take & (cmd == `CMD_READ);
  wire is_wr    = cmd_take & (cmd == `CMD_WRITE);
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      row_open_cmd_q <= 1'b0;
      precharge_q    <= 1'b0;
      read_q         <= 1'b0;
      write_q        <= 1'b0;
      cmd_bank_q     <= 3'h0;
      row_addr_q     <= 14'h0000;
      col_addr_q     <= 10'h000;
      auto_pre_q     <= 1'b0;
    end else begin
      row_open_cmd_q <= is_open;
      precharge_q    <= is_pre;
      read_q         <= is_rd;
      write_q        <= is_wr;
      if (is_open || is_pre || is_rd || is_wr) begin
        cmd_bank_q <= bank;
      end
      if (is_open) begin
        row_addr_q <= addr;
      end
      if (is_rd || is_wr) begin
        col_addr_q <= addr[`COL_W-1:0];
        auto_pre_q <= addr[`AUTOPRE_BIT];
      end
    end
  end

  // per-bank state: open on row-open, idle after precharge time elapses
  genvar b;
  generate
    for (b = 0; b < `BANKS; b = b + 1) begin : g_bank
      reg [3:0] pre_cnt_q;
      always @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          bank_active_q[b] <= 1'b0;
          pre_cnt_q        <= 4'h0;
        end else if (is_open && bank == b) begin
          bank_active_q[b] <= 1'b1;
          pre_cnt_q        <= 4'h0;
        end else if (is_pre && bank == b) begin
          pre_cnt_q        <= `PRE_CYCLES;
        end else if (pre_cnt_q != 4'h0) begin
          pre_cnt_q <= pre_cnt_q - 4'h1;
          if (pre_cnt_q == 4'h1) begin
            bank_active_q[b] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // termination gated by the config field; pin ignored when disabled
  wire term_cfg = |extended_config_reg1[`ECR1_TERM_HI:`ECR1_TERM_LO];
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      term_on_q <= 1'b0;
    end else begin
      term_on_q <= term_cfg & odt_s;
    end
  end

  // bit set means complements off, cleared means differential
  wire comp_en = ~extended_config_reg1[`ECR1_STROBE_COMP_OFF];

  // two lanes share one module; lane i carries bits 8i..8i+7
  wire [1:0] mask_v = {udm_s, ldm_s};
  wire [1:0] strobe_o;
  wire [1:0] strobe_e;
  wire [1:0] strobe_co;
  wire [1:0] strobe_ce;
  genvar l;
  generate
    for (l = 0; l < 2; l = l + 1) begin : g_lane
      wire dq_e;
      ddr2_lane_path u_lane (
        .clk          (clk),
        .rst_sync_b   (rst_sync_b),
        .rise_edge    (rise_edge),
        .fall_edge    (fall_edge),
        .wr_window    (wr_window),
        .rd_window    (rd_window),
        .comp_en      (comp_en),
        .dq_in_s      (dq_s[l*8+7:l*8]),
        .mask_s       (mask_v[l]),
        .rd_byte      (rd_data[l*8+7:l*8]),
        .wr_byte_q    (wr_data[l*8+7:l*8]),
        .wr_valid_q   (wr_lane_valid[l]),
        .dq_out_q     (data_lines_out[l*8+7:l*8]),
        .dq_oe        (dq_e),
        .strobe_out_q (strobe_o[l]),
        .strobe_oe    (strobe_e[l]),
        .strobe_c_out (strobe_co[l]),
        .strobe_c_oe  (strobe_ce[l])
      );
      assign data_lines_oe[l*8+7:l*8] = {8{dq_e}};
    end
  endgenerate
  assign lower_byte_strobe_out      = strobe_o[0];
  assign lower_byte_strobe_oe       = strobe_e[0];
  assign lower_byte_strobe_comp_out = strobe_co[0];
  assign lower_byte_strobe_comp_oe  = strobe_ce[0];
  assign upper_byte_strobe_out      = strobe_o[1];
  assign upper_byte_strobe_oe       = strobe_e[1];
  assign upper_byte_strobe_comp_out = strobe_co[1];
  assign upper_byte_strobe_comp_oe  = strobe_ce[1];
endmodule
`default_nettype wire

// ===== dv/ddr2_pin_sva.sv
// port assertions for the pin command decode
// assumes a bind onto ddr2_pin_command_decode, one clk domain
`timescale 1ns/1ps
`default_nettype none
module ddr2_pin_sva (
  input wire logic        clk,                        // system clock
  input wire logic        rst_b,                      // reset, active low
  input wire logic        chip_select_n,              // chip select pin
  input wire logic        termination_enable,         // termination pin
  input wire logic [13:0] extended_config_reg1,       // config value
  input wire logic        rd_window,                  // read drive window
  input wire logic [15:0] data_lines_oe,              // data enables
  input wire logic        lower_byte_strobe_out,      // lower strobe
  input wire logic        lower_byte_strobe_comp_out, // lower complement
  input wire logic        lower_byte_strobe_comp_oe,  // lower comp enable
  input wire logic        upper_byte_strobe_out,      // upper strobe
  input wire logic        upper_byte_strobe_comp_out, // upper complement
  input wire logic        upper_byte_strobe_comp_oe,  // upper comp enable
  input wire logic        row_open_cmd_q,             // row-open pulse
  input wire logic        precharge_q,                // precharge pulse
  input wire logic        read_q,                     // read pulse
  input wire logic        write_q,                    // write pulse
  input wire logic [2:0]  cmd_bank_q,                 // command bank
  input wire logic [7:0]  bank_active_q,              // open banks
  input wire logic        term_on_q                   // termination applied
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // any decoded command this cycle
  wire any_cmd = row_open_cmd_q | precharge_q | read_q | write_q;
  property p_onehot; $onehot0({row_open_cmd_q, precharge_q, read_q, write_q}); endproperty
  a_onehot: assert property (p_onehot) else $error("two command pulses at once");
  // deselect must outlast the sync and decode pipe before nothing may show
  property p_desel; chip_select_n [*8] |-> !any_cmd; endproperty
  a_desel: assert property (p_desel) else $error("command while deselected");
  property p_open; row_open_cmd_q |=> bank_active_q[cmd_bank_q]; endproperty
  a_open: assert property (p_open) else $error("row open left bank idle");
  property p_pre; precharge_q |-> ##[1:6] !bank_active_q[cmd_bank_q]; endproperty
  a_pre: assert property (p_pre) else $error("bank still open after precharge");
  property p_bank; !$stable(cmd_bank_q) |-> any_cmd; endproperty
  a_bank: assert property (p_bank) else $error("bank moved without command");
  property p_dq_oe; data_lines_oe == {16{rd_window}}; endproperty
  a_dq_oe: assert property (p_dq_oe) else $error("data enable off read window");
  property p_comp; rd_window |-> lower_byte_strobe_comp_out != lower_byte_strobe_out
    && upper_byte_strobe_comp_out != upper_byte_strobe_out; endproperty
  a_comp: assert property (p_comp) else $error("complement equals strobe");
  property p_comp_oe; {lower_byte_strobe_comp_oe, upper_byte_strobe_comp_oe}
    == {2{rd_window & ~extended_config_reg1[10]}}; endproperty
  a_comp_oe: assert property (p_comp_oe) else $error("complement enables disagree");
  property p_term_off; (extended_config_reg1[6:2] == 5'h00) [*6] |-> !term_on_q; endproperty
  a_term_off: assert property (p_term_off) else $error("termination while disabled");
  property p_term_on; (termination_enable && extended_config_reg1[6:2] != 5'h00) [*8]
    |-> term_on_q; endproperty
  a_term_on: assert property (p_term_on) else $error("termination not applied");
  c_open: cover property (row_open_cmd_q);
  c_pre: cover property (precharge_q);
  c_read: cover property (rd_window && lower_byte_strobe_out);
endmodule
bind ddr2_pin_command_decode ddr2_pin_sva u_sva (.clk(clk), .rst_b(rst_b),
  .chip_select_n(chip_select_n), .termination_enable(termination_enable),
  .extended_config_reg1(extended_config_reg1), .rd_window(rd_window),
  .data_lines_oe(data_lines_oe), .lower_byte_strobe_out(lower_byte_strobe_out),
  .lower_byte_strobe_comp_out(lower_byte_strobe_comp_out),
  .lower_byte_strobe_comp_oe(lower_byte_strobe_comp_oe),
  .upper_byte_strobe_out(upper_byte_strobe_out),
  .upper_byte_strobe_comp_out(upper_byte_strobe_comp_out),
  .upper_byte_strobe_comp_oe(upper_byte_strobe_comp_oe), .row_open_cmd_q(row_open_cmd_q),
  .precharge_q(precharge_q), .read_q(read_q), .write_q(write_q), .cmd_bank_q(cmd_bank_q),
  .bank_active_q(bank_active_q), .term_on_q(term_on_q));
`default_nettype wire

// ===== dv/ddr2_ctl_model.sv
// controller-side model: link clock, command pins, write data and masks
// assumes the bench calls issue and beat just after a clk edge
`timescale 1ns/1ps
`default_nettype none
module ddr2_ctl_model (
  input  wire logic        clk,             // system clock, pin timing
  output var  logic        clock_true,      // link clock
  output var  logic        clock_comp,      // link clock complement
  output var  logic        chip_select_n,   // chip select
  output var  logic        row_strobe_n,    // row strobe
  output var  logic        column_strobe_n, // column strobe
  output var  logic        write_select_n,  // write select
  output var  logic [13:0] address_lines,   // address pins
  output var  logic [2:0]  bank_select,     // bank pins
  output var  logic [15:0] data_lines_in,   // write data pins
  output var  logic        lower_byte_mask, // lower lane mask
  output var  logic        upper_byte_mask  // upper lane mask
);
  // free-running link clock, offset so crossings never meet a clk edge
  initial begin
    {clock_true, clock_comp} = 2'b01;
    {chip_select_n, row_strobe_n, column_strobe_n, write_select_n} = 4'hF;
    {address_lines, bank_select, data_lines_in} = 33'h0;
    {upper_byte_mask, lower_byte_mask} = 2'b11;
    #3;
    forever #40 {clock_true, clock_comp} = ~{clock_true, clock_comp};
  end
  // pins set after a falling crossing, held past the rising one, then deselected with address and bank inverted
  task automatic issue(input logic [3:0] code, input logic [13:0] a, input logic [2:0] b);
    @(negedge clock_true);
    @(posedge clk);
    #1;
    {chip_select_n, row_strobe_n, column_strobe_n, write_select_n} = code;
    address_lines = a;
    bank_select = b;
    @(posedge clock_true);
    repeat (5) @(posedge clk);
    #1;
    {chip_select_n, row_strobe_n, column_strobe_n, write_select_n} = 4'hF;
    address_lines = ~a;
    bank_select = ~b;
  endtask
  // one word per crossing, changed three clk edges after it so sync flops see it settled
  task automatic beat(input logic [15:0] d, input logic [1:0] m);
    @(clock_true);
    repeat (3) @(posedge clk);
    #1;
    data_lines_in = d;
    {upper_byte_mask, lower_byte_mask} = m;
  endtask
endmodule
`default_nettype wire

// ===== dv/ddr2_pin_command_decode_tb_top.sv
// self-checking bench for the pin command decode
// assumes ddr2_ctl_model drives the pins and the link clock
`timescale 1ns/1ps
`default_nettype none
module ddr2_pin_command_decode_tb_top;
  logic clk = 1'b0, rst_b = 1'b0, wr_window = 1'b0, rd_window = 1'b0, termination_enable = 1'b0;
  logic clock_true, clock_comp, chip_select_n, row_strobe_n, column_strobe_n, write_select_n;
  logic lower_byte_mask, upper_byte_mask, row_open_cmd_q, precharge_q, read_q, write_q;
  logic lso, lsoe, lsco, lscoe, uso, usoe, usco, uscoe, auto_pre_q, term_on_q, eap;
  logic [13:0] address_lines, row_addr_q, er, extended_config_reg1 = 14'h0000;
  logic [15:0] data_lines_in, data_lines_out, data_lines_oe, wr_data, ew, rd_data = 16'h0000;
  logic [2:0]  bank_select, cmd_bank_q, eb;
  logic [9:0]  col_addr_q, ecol;
  logic [7:0]  bank_active_q, ea;
  logic [1:0]  wr_lane_valid;
  logic [3:0]  code;
  logic [3:0]  codes [8] = '{4'h3, 4'h2, 4'h5, 4'h4, 4'h7, 4'h1, 4'h0, 4'hB};
  logic [31:0] rs = 32'h00007F03, r;
  int nc[4] = '{0, 0, 0, 0}, ec[4] = '{0, 0, 0, 0}, nv[2] = '{0, 0}, ev[2] = '{0, 0};
  int err_total = 0, check_count = 0, i, j, k;
  ddr2_ctl_model ctl (.clk(clk), .clock_true(clock_true), .clock_comp(clock_comp),
    .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n), .write_select_n(write_select_n),
    .address_lines(address_lines), .bank_select(bank_select), .data_lines_in(data_lines_in),
    .lower_byte_mask(lower_byte_mask), .upper_byte_mask(upper_byte_mask));
  ddr2_pin_command_decode dut (.clk(clk), .rst_b(rst_b), .clock_true(clock_true),
    .clock_comp(clock_comp), .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n), .write_select_n(write_select_n),
    .address_lines(address_lines), .bank_select(bank_select),
    .termination_enable(termination_enable), .extended_config_reg1(extended_config_reg1),
    .wr_window(wr_window), .rd_window(rd_window), .data_lines_in(data_lines_in),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
    .lower_byte_mask(lower_byte_mask), .upper_byte_mask(upper_byte_mask), .rd_data(rd_data),
    .wr_data(wr_data), .wr_lane_valid(wr_lane_valid), .lower_byte_strobe_out(lso),
    .lower_byte_strobe_oe(lsoe), .lower_byte_strobe_comp_out(lsco),
    .lower_byte_strobe_comp_oe(lscoe), .upper_byte_strobe_out(uso),
    .upper_byte_strobe_oe(usoe), .upper_byte_strobe_comp_out(usco),
    .upper_byte_strobe_comp_oe(uscoe), .row_open_cmd_q(row_open_cmd_q),
    .precharge_q(precharge_q), .read_q(read_q), .write_q(write_q), .cmd_bank_q(cmd_bank_q),
    .row_addr_q(row_addr_q), .col_addr_q(col_addr_q), .auto_pre_q(auto_pre_q),
    .bank_active_q(bank_active_q), .term_on_q(term_on_q));
  always #4 clk = ~clk;
  // pulse counters, so a missed or doubled pulse shows in the totals
  always @(posedge clk) begin
    nc <= '{nc[0] + row_open_cmd_q, nc[1] + precharge_q, nc[2] + read_q, nc[3] + write_q};
    nv <= '{nv[0] + wr_lane_valid[0], nv[1] + wr_lane_valid[1]};
  end
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    if (err_total == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // bounded wait for the next link crossing, returns on the 5th clk edge after it
  task automatic link_edge;
    logic l;
    int n;
    l = clock_true;
    n = 0;
    while (clock_true === l && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) begin
      err_total++;
      end_sim;
    end
    repeat (4) @(posedge clk);
    #1;
  endtask
  // watchdog: a stuck wait on the link clock ends the run as a failure
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    end_sim;
  end
  initial begin
    {er, ew, eb, ecol, ea, eap} = '0;
    repeat (10) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    // random command mix, deselect and non-decoded codes among them
    for (i = 0; i < 40; i++) begin
      r = rnd();
      code = codes[r[2:0]];
      ctl.issue(code, r[29:16], r[12:10]);
      repeat (5) @(posedge clk);
      #1;
      case (code)
        4'h3: begin ec[0]++; ea[r[12:10]] = 1'b1; er = r[29:16]; eb = r[12:10]; end
        4'h2: begin ec[1]++; ea[r[12:10]] = 1'b0; eb = r[12:10]; end
        4'h5, 4'h4: begin ec[code[0] ? 2 : 3]++; eb = r[12:10]; ecol = r[25:16]; eap = r[26]; end
        default: ;
      endcase
      for (k = 0; k < 4; k++) chk(16'(nc[k]), 16'(ec[k]));
      chk({8'h00, bank_active_q}, {8'h00, ea});
      chk({2'h0, row_addr_q}, {2'h0, er});
      chk({5'h00, auto_pre_q, col_addr_q}, {5'h00, eap, ecol});
      chk({13'h0000, cmd_bank_q}, {13'h0000, eb});
    end
    // write burst: first word unmasked, last fully masked
    for (i = 0; i < 8; i++) begin
      r = rnd();
      if (i == 0 || i == 7) r[17:16] = (i == 0) ? 2'b00 : 2'b11;
      ctl.beat(r[15:0], r[17:16]);
      if (i == 0) wr_window = 1'b1;
      if (!r[16]) begin ev[0]++; ew[7:0] = r[7:0]; end
      if (!r[17]) begin ev[1]++; ew[15:8] = r[15:8]; end
    end
    link_edge;
    wr_window = 1'b0;
    chk(wr_data, ew);
    chk(16'(nv[0]), 16'(ev[0]));
    chk(16'(nv[1]), 16'(ev[1]));
    // reads with complements on, then off
    for (j = 0; j < 2; j++) begin
      extended_config_reg1[10] = j[0];
      r = rnd();
      rd_data = r[15:0];
      rd_window = 1'b1;
      for (i = 0; i < 6; i++) begin
        link_edge;
        chk(data_lines_out, rd_data);
        chk({12'h000, lsoe, usoe, uso, lso}, {12'h000, 2'b11, {2{clock_true}}});
        chk({14'h0000, lscoe, uscoe}, {14'h0000, {2{~j[0]}}});
        r = rnd();
        rd_data = r[15:0];
      end
      // let an edge pass so the window is not raised again in the same step
      rd_window = 1'b0;
      @(posedge clk);
      #1;
    end
    // termination pin against the enable field
    for (i = 0; i < 8; i++) begin
      r = rnd();
      if (i < 2) r[1:0] = {~i[0], 1'b1}; // corners: enabled, then pin with field off
      termination_enable = r[0];
      extended_config_reg1 = r[1] ? 14'(14'h0004 << (r[4:2] % 3'h5)) : 14'h0000;
      repeat (10) @(posedge clk);
      #1;
      chk({15'h0000, term_on_q}, {15'h0000, r[0] & r[1]});
    end
    end_sim;
  end
endmodule
`default_nettype wire
